// ### logic/ifei_pkg.sv
// package for input filter and external interrupt block
package ifei_pkg;
	localparam int unsigned IFEI_NUM_INPUTS = 16;
	localparam int unsigned IFEI_NUM_EXT = 8;
	localparam int unsigned IFEI_NUM_EXT_ECO = 4;
	// clock and millisecond tick
	localparam int unsigned IFEI_CLK_HZ = 200000000;
	localparam int unsigned IFEI_MS_PER_TICK = 1;
	localparam int unsigned IFEI_TICK_CYCLES = IFEI_CLK_HZ / 1000 * IFEI_MS_PER_TICK;
	localparam int unsigned IFEI_CNT_W = 10;
	// filter delay codes, index into delay table
	localparam logic [3:0] IFEI_DLY_CODE_RESET = 4'h4;
	localparam logic [3:0] IFEI_DLY_CODE_MAX = 4'hA;
	// register offsets
	localparam logic [3:0] IFEI_REG_FILTER = 4'h0;
	localparam logic [3:0] IFEI_REG_EXT_EN = 4'h1;
	localparam logic [3:0] IFEI_REG_EDGE = 4'h2;
	localparam logic [3:0] IFEI_REG_VARIANT = 4'h3;
	localparam logic [3:0] IFEI_REG_LEVEL = 4'h4;
	localparam logic [3:0] IFEI_REG_STATUS = 4'h5;
	localparam logic [3:0] IFEI_REG_MASK = 4'h6;
	localparam logic [3:0] IFEI_REG_RESERVE = 4'h7;
	// edge select per source (2 bits)
	localparam logic [1:0] IFEI_EDGE_RISE = 2'h0;
	localparam logic [1:0] IFEI_EDGE_FALL = 2'h1;
	localparam logic [1:0] IFEI_EDGE_BOTH = 2'h2;
	// reset values
	localparam logic [7:0] IFEI_EXT_EN_RESET = 8'h00;
	localparam logic [15:0] IFEI_EDGE_RESET = 16'h0000;
	localparam logic [7:0] IFEI_MASK_RESET = 8'h00;
	localparam logic [3:0] IFEI_RESERVE_RESET = 4'h0;
	localparam logic IFEI_VARIANT_RESET = 1'b0;
endpackage

// ### logic/ifei_top.sv
// input filter with edge-triggered external interrupt sources
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
// register map, 4-bit index, 16-bit data
//   0 filter delay code, 0..10 for 0 to 1000 ms, larger codes refused
//   1 source enable, one bit per external source
//   2 edge mode, two bits per source: rise, fall, both, none
//   3 variant, bit 0 set selects the economic variant
//   4 filtered levels of all sixteen inputs, read only
//   5 sticky edge status, cleared by its own read
//   6 interrupt mask, same layout as the status
//   7 sources lent to other interrupt users, 0 to 8
// timing seen at the ports
//   writes take effect on the edge that samples the strobe
//   read data stand for one cycle after the read strobe, else zero
//   a request pulse follows a filtered edge by one cycle
//   status and interrupt rise together with the request pulse
//   an edge in the same cycle as a status read stays set
// filter behaviour
//   the tick divider runs free, so the first tick of a count may
//   come early: a held level is taken after one tick less at worst
//   code 0 passes the raw level through one register only
//   a level that returns before its count ends is dropped
// interrupt sources
//   only the lowest eight inputs can raise requests
//   the economic variant keeps four of them, rising edges only
//   lent sources are taken from the highest number downwards
//   a pin claimed by the counter never raises a request
//   requests are raised at once, not at the end of a scan
module ifei_top
	import ifei_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = IFEI_TICK_CYCLES
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	// field inputs
	input wire logic [IFEI_NUM_INPUTS-1:0] raw_in,
	input wire logic [IFEI_NUM_EXT-1:0] high_speed_counter_input_in,
	// register port
	input wire logic [3:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	// conditioned inputs and requests
	output logic [IFEI_NUM_INPUTS-1:0] filtered_out,
	output logic [IFEI_NUM_EXT-1:0] ext_req_out,
	output logic irq_out
);

	// delay table in ms, code to delay
	function automatic logic [IFEI_CNT_W-1:0] dly_ms(input logic [3:0] code);
		case (code)
			4'h0: dly_ms = 10'h000;
			4'h1: dly_ms = 10'h001;
			4'h2: dly_ms = 10'h002;
			4'h3: dly_ms = 10'h005;
			4'h4: dly_ms = 10'h00A;
			4'h5: dly_ms = 10'h014;
			4'h6: dly_ms = 10'h032;
			4'h7: dly_ms = 10'h064;
			4'h8: dly_ms = 10'h0C8;
			4'h9: dly_ms = 10'h1F4;
			default: dly_ms = 10'h3E8;
		endcase
	endfunction

	// registers
	logic [3:0] dly_code_q;
	logic [IFEI_NUM_EXT-1:0] ext_en_q;
	logic [2*IFEI_NUM_EXT-1:0] edge_q;
	logic economic_q;
	logic [3:0] reserve_q;
	logic [IFEI_NUM_EXT-1:0] status_q;
	logic [IFEI_NUM_EXT-1:0] mask_q;
	logic [15:0] rdata_q;
	logic irq_q;

	// filter state
	logic [31:0] tick_cnt_q;
	logic tick_q;
	logic [IFEI_CNT_W-1:0] flt_cnt_q [IFEI_NUM_INPUTS];
	logic [IFEI_NUM_INPUTS-1:0] flt_q;
	logic [IFEI_NUM_EXT-1:0] prev_q;
	logic [IFEI_NUM_EXT-1:0] req_q;

	// decode
	wire wr_filter = reg_wr_in && (reg_addr_in == IFEI_REG_FILTER);
	wire wr_ext_en = reg_wr_in && (reg_addr_in == IFEI_REG_EXT_EN);
	wire wr_edge = reg_wr_in && (reg_addr_in == IFEI_REG_EDGE);
	wire wr_variant = reg_wr_in && (reg_addr_in == IFEI_REG_VARIANT);
	wire wr_mask = reg_wr_in && (reg_addr_in == IFEI_REG_MASK);
	wire wr_reserve = reg_wr_in && (reg_addr_in == IFEI_REG_RESERVE);
	wire rd_status = reg_rd_in && (reg_addr_in == IFEI_REG_STATUS);
	// out-of-table codes are refused, the setting keeps its old value
	wire filter_ok = (reg_wdata_in[15:4] == 12'h000)
		&& (reg_wdata_in[3:0] <= IFEI_DLY_CODE_MAX);
	wire [IFEI_CNT_W-1:0] dly_now = dly_ms(dly_code_q);
	wire tick_wrap = (tick_cnt_q >= TICK_CYCLES - 1);

	// sources usable: variant sources minus those claimed from source 7 down by other interrupt users
	wire [IFEI_NUM_EXT-1:0] variant_cap = economic_q ? 8'h0F : 8'hFF;
	// highest sources are given up first when other users claim them
	wire [IFEI_NUM_EXT-1:0] reserve_mask_hi = ~(8'hFF >> reserve_q);
	wire [IFEI_NUM_EXT-1:0] src_en = ext_en_q & variant_cap & ~reserve_mask_hi;

	// edge detection on filtered levels, per source mode
	wire [IFEI_NUM_EXT-1:0] rise_now = flt_q[IFEI_NUM_EXT-1:0] & ~prev_q;
	wire [IFEI_NUM_EXT-1:0] fall_now = ~flt_q[IFEI_NUM_EXT-1:0] & prev_q;
	// the economic variant offers rising edges only, whatever is stored
	wire force_rise = economic_q;

	// one source's edge decision, mode 3 selects no edge at all
	function automatic logic edge_sel(input logic [1:0] md, input logic r, input logic f);
		case (md)
			IFEI_EDGE_RISE: edge_sel = r;
			IFEI_EDGE_FALL: edge_sel = f;
			IFEI_EDGE_BOTH: edge_sel = r || f;
			default: edge_sel = 1'b0;
		endcase
	endfunction

	// counter pins never act as capture points, so they stay plain inputs
	logic [IFEI_NUM_EXT-1:0] hit;
	always_comb begin
		hit = '0;
		for (int i = 0; i < IFEI_NUM_EXT; i++) begin
			if (force_rise) begin
				hit[i] = rise_now[i];
			end else begin
				hit[i] = edge_sel(edge_q[2*i +: 2], rise_now[i], fall_now[i]);
			end
		end
		// gating last, so a disabled source never leaves a stale status
		hit = hit & src_en & ~high_speed_counter_input_in;
	end

	// read mux
	logic [15:0] rmux;
	always_comb begin
		case (reg_addr_in)
			IFEI_REG_FILTER: rmux = {12'h000, dly_code_q};
			IFEI_REG_EXT_EN: rmux = {8'h00, ext_en_q};
			IFEI_REG_EDGE: rmux = edge_q;
			IFEI_REG_VARIANT: rmux = {15'h0000, economic_q};
			IFEI_REG_LEVEL: rmux = flt_q;
			IFEI_REG_STATUS: rmux = {8'h00, status_q};
			IFEI_REG_MASK: rmux = {8'h00, mask_q};
			IFEI_REG_RESERVE: rmux = {12'h000, reserve_q};
			default: rmux = 16'h0000;
		endcase
	end

	// millisecond tick divider, a one-cycle enable pulse
	wire [31:0] tick_cnt_d = tick_wrap ? 32'h00000000 : tick_cnt_q + 32'h00000001;

	// divider count
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tick_cnt_q <= 32'h00000000;
		end else begin
			tick_cnt_q <= tick_cnt_d;
		end
	end

	// tick pulse, one clock wide, drives every filter counter
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= tick_wrap;
		end
	end

	// next filter state, same delay for all inputs
	logic [IFEI_NUM_INPUTS-1:0] flt_d;
	logic [IFEI_CNT_W-1:0] flt_cnt_d [IFEI_NUM_INPUTS];
	always_comb begin
		flt_d = flt_q;
		for (int i = 0; i < IFEI_NUM_INPUTS; i++) begin
			flt_cnt_d[i] = flt_cnt_q[i];
			if (raw_in[i] == flt_q[i]) begin
				// a level that returns before the count ends is forgotten
				flt_cnt_d[i] = '0;
			end else if (dly_now == '0) begin
				flt_d[i] = raw_in[i];
			end else if (tick_q) begin
				// level must hold through the whole count before taken
				if (flt_cnt_q[i] + 10'h001 >= dly_now) begin
					flt_d[i] = raw_in[i];
					flt_cnt_d[i] = '0;
				end else begin
					flt_cnt_d[i] = flt_cnt_q[i] + 10'h001;
				end
			end
		end
	end

	// filtered levels
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			flt_q <= '0;
		end else begin
			flt_q <= flt_d;
		end
	end

	// filter counters, one per input
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < IFEI_NUM_INPUTS; i++) begin
				flt_cnt_q[i] <= '0;
			end
		end else begin
			flt_cnt_q <= flt_cnt_d;
		end
	end

	// filter delay code, refused codes leave it alone
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			dly_code_q <= IFEI_DLY_CODE_RESET;
		end else if (wr_filter && filter_ok) begin
			dly_code_q <= reg_wdata_in[3:0];
		end
	end

	// source enables
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ext_en_q <= IFEI_EXT_EN_RESET;
		end else if (wr_ext_en) begin
			ext_en_q <= reg_wdata_in[7:0];
		end
	end

	// edge modes, two bits per source
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			edge_q <= IFEI_EDGE_RESET;
		end else if (wr_edge) begin
			edge_q <= reg_wdata_in;
		end
	end

	// variant select, kept as a bit so one netlist serves both
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			economic_q <= IFEI_VARIANT_RESET;
		end else if (wr_variant) begin
			economic_q <= reg_wdata_in[0];
		end
	end

	// interrupt mask
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mask_q <= IFEI_MASK_RESET;
		end else if (wr_mask) begin
			mask_q <= reg_wdata_in[7:0];
		end
	end

	// lent sources, bit 3 adds one so that all eight can be lent
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			reserve_q <= IFEI_RESERVE_RESET;
		end else if (wr_reserve) begin
			reserve_q <= {1'b0, reg_wdata_in[2:0]} + {3'h0, reg_wdata_in[3]};
		end
	end

	// next sticky status and interrupt, set beats read-clear
	wire [IFEI_NUM_EXT-1:0] status_kept = rd_status ? 8'h00 : status_q;
	wire [IFEI_NUM_EXT-1:0] status_d = status_kept | hit;
	wire irq_d = |(status_d & mask_q);
	// read data are zero outside the answer cycle
	wire [15:0] rdata_d = reg_rd_in ? rmux : 16'h0000;

	// edge history, one cycle behind the filtered levels
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			prev_q <= '0;
		end else begin
			prev_q <= flt_q[IFEI_NUM_EXT-1:0];
		end
	end

	// request pulses, one cycle per accepted edge
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			req_q <= '0;
		end else begin
			req_q <= hit;
		end
	end

	// sticky status
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			status_q <= '0;
		end else begin
			status_q <= status_d;
		end
	end

	// level interrupt, registered so the pin never glitches
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	// read data register
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// outputs straight from flip-flops
	assign reg_rdata_out = rdata_q;
	assign filtered_out = flt_q;
	assign ext_req_out = req_q;
	assign irq_out = irq_q;
endmodule
`default_nettype wire

// ### dv/ifei_asserts.sv
// port checks on the filter and interrupt block
`timescale 1ns/100ps
`default_nettype none
module ifei_asserts
	import ifei_pkg::*;
(
	// watched ports
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic [15:0] raw_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic reg_rd_in,
	input wire logic reg_wr_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic [15:0] filtered_out,
	input wire logic [7:0] ext_req_out,
	input wire logic irq_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);
	// a filtered bit may only move to the level raw already had
	property p_fil; $changed(filtered_out) |-> ((filtered_out ^ $past(filtered_out))
		& (filtered_out ^ $past(raw_in))) == 16'h0000; endproperty
	a_fil: assert property (p_fil) else $error("filter moved early");
	property p_req; ext_req_out != 8'h00 |-> (ext_req_out
		& ~($past(filtered_out[7:0]) ^ $past(filtered_out[7:0], 2))) == 8'h00; endproperty
	a_req: assert property (p_req) else $error("request without edge");
	property p_rd0; !$past(reg_rd_in) |-> reg_rdata_out == 16'h0000; endproperty
	a_rd0: assert property (p_rd0) else $error("stray read data");
	property p_lvl; $past(reg_rd_in) && $past(reg_addr_in) == IFEI_REG_LEVEL
		|-> reg_rdata_out == $past(filtered_out); endproperty
	a_lvl: assert property (p_lvl) else $error("level read wrong");
	property p_flt; $past(reg_rd_in) && $past(reg_addr_in) == IFEI_REG_FILTER
		|-> reg_rdata_out <= 16'h000A; endproperty
	a_flt: assert property (p_flt) else $error("filter code out of range");
	property p_irqr; $rose(irq_out) |-> ext_req_out != 8'h00 || $past(reg_wr_in)
		|| $past(reg_wr_in, 2); endproperty
	a_irqr: assert property (p_irqr) else $error("irq rose alone");
	property p_irqf; $fell(irq_out) |-> $past(reg_rd_in) || $past(reg_rd_in, 2)
		|| $past(reg_wr_in) || $past(reg_wr_in, 2); endproperty
	a_irqf: assert property (p_irqf) else $error("irq fell alone");
	// outputs are cleared asynchronously, so checked with no disable
	property p_rst; disable iff (1'b0) !rstn_in
		|-> {filtered_out, ext_req_out, irq_out, reg_rdata_out} == 41'h0; endproperty
	a_rst: assert property (p_rst) else $error("output live in reset");
	c_req: cover property (ext_req_out != 8'h00);
	c_irq: cover property ($rose(irq_out));
	c_lvl: cover property ($past(reg_rd_in) && $past(reg_addr_in) == IFEI_REG_LEVEL);
endmodule
bind ifei_top ifei_asserts u_chk (.ref_clk_in, .rstn_in, .raw_in, .reg_addr_in, .reg_rd_in,
	.reg_wr_in, .reg_rdata_out, .filtered_out, .ext_req_out, .irq_out);
`default_nettype wire

// ### dv/ifei_field.sv
// field contact model driving the raw inputs
`timescale 1ns/100ps
`default_nettype none
module ifei_field (
	// clock and wanted levels
	input wire logic ref_clk_in,
	input wire logic [15:0] level_in,
	// contacts toward the block
	output logic [15:0] raw_out
);
	logic [15:0] hold_q = 16'h0000;
	// contacts settle after an edge, so raw is synchronous to the block
	always @(posedge ref_clk_in) begin
		hold_q <= level_in;
	end
	assign raw_out = hold_q;
endmodule
`default_nettype wire

// ### dv/tb.sv
// bench for the filter and interrupt block
`timescale 1ns/100ps
`default_nettype none
module tb;
	import ifei_pkg::*;
	typedef struct {logic eco; int s; logic [1:0] e; logic up; logic dn;} ifei_row_t;
	logic ref_clk_in = 1'b0, rstn_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0, irq_out, b;
	logic [15:0] lvl = 16'h0000, raw_in, reg_wdata_in = 16'h0000, reg_rdata_out, filtered_out, x;
	logic [3:0] reg_addr_in = 4'h0;
	logic [7:0] ext_req_out, high_speed_counter_input = 8'h00;
	int n_errors = 0, num_checks = 0, t;
	// source, edge mode, request expected on rise and on fall
	ifei_row_t rows [6] = '{'{0, 0, IFEI_EDGE_RISE, 1, 0}, '{0, 1, IFEI_EDGE_FALL, 0, 1},
		'{0, 7, IFEI_EDGE_BOTH, 1, 1}, '{0, 2, 2'h3, 0, 0}, '{1, 0, IFEI_EDGE_BOTH, 1, 0},
		'{1, 5, IFEI_EDGE_RISE, 0, 0}};
	always #2.5 ref_clk_in = ~ref_clk_in;
	ifei_field field (.ref_clk_in, .level_in(lvl), .raw_out(raw_in));
	// counter pins start low: no point is handed to the counter before the counter-pin case
	ifei_top #(.TICK_CYCLES(4)) dut (.ref_clk_in, .rstn_in, .raw_in, .reg_addr_in,
		.high_speed_counter_input_in(high_speed_counter_input), .reg_wdata_in, .reg_wr_in, .reg_rd_in,
		.reg_rdata_out, .filtered_out, .ext_req_out, .irq_out);
	task automatic complete_run;
		if (n_errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b0;
		#1 chk(reg_rdata_out, exp);
	endtask
	// move one contact and count cycles until it filters, bounded
	task automatic mv(input int i, input logic v);
		@(posedge ref_clk_in);
		lvl[i] <= v;
		t = 0;
		do begin
			@(posedge ref_clk_in);
			#1 t++;
		end while (filtered_out[i] !== v && t < 300);
		if (filtered_out[i] !== v) begin
			n_errors++;
			$display("wrong value at %0t: input %0d never settled", $time, i);
			complete_run();
		end else begin
			@(posedge ref_clk_in);
		end
	endtask
	initial begin
		rstn_in <= 1'b0;
		repeat (3) @(posedge ref_clk_in);
		rstn_in <= 1'b1;
		rd(IFEI_REG_FILTER, 16'h0004);
		mv(3, 1'b1);
		chk(16'(t > 34 && t < 45), 16'h0001);
		wr(IFEI_REG_FILTER, 16'h000B);
		rd(IFEI_REG_FILTER, 16'h0004);
		lvl[4] <= 1'b1;
		repeat (20) @(posedge ref_clk_in);
		lvl <= 16'h0000;
		repeat (50) @(posedge ref_clk_in);
		#1 chk(filtered_out, 16'h0000);
		wr(IFEI_REG_FILTER, 16'h0000);
		lvl <= 16'hFFFF;
		repeat (3) @(posedge ref_clk_in);
		rd(IFEI_REG_LEVEL, 16'hFFFF);
		wr(IFEI_REG_FILTER, 16'h0001);
		lvl <= 16'h0000;
		foreach (rows[r]) begin
			wr(IFEI_REG_VARIANT, 16'(rows[r].eco));
			wr(IFEI_REG_EDGE, 16'(rows[r].e) << (2 * rows[r].s));
			wr(IFEI_REG_EXT_EN, 16'h0001 << rows[r].s);
			wr(IFEI_REG_MASK, 16'h0001 << rows[r].s);
			for (int p = 1; p >= 0; p--) begin
				b = p ? rows[r].up : rows[r].dn;
				mv(rows[r].s, p[0]);
				x = {8'(b) << rows[r].s, 7'h00, b};
				#1 chk({ext_req_out, 7'h00, irq_out}, x);
				rd(IFEI_REG_STATUS, x >> 8);
			end
		end
		// two sources lent to other interrupt users, status masked
		wr(IFEI_REG_VARIANT, 16'h0000);
		wr(IFEI_REG_EDGE, 16'h0000);
		wr(IFEI_REG_EXT_EN, 16'h00FF);
		wr(IFEI_REG_MASK, 16'h0000);
		wr(IFEI_REG_RESERVE, 16'h0009);
		rd(IFEI_REG_RESERVE, 16'h0002);
		mv(6, 1'b1);
		mv(5, 1'b1);
		#1 chk({ext_req_out, 7'h00, irq_out}, 16'h2000);
		wr(IFEI_REG_MASK, 16'h00FF);
		repeat (2) @(posedge ref_clk_in);
		#1 chk(16'(irq_out), 16'h0001);
		rd(IFEI_REG_STATUS, 16'h0020);
		repeat (2) @(posedge ref_clk_in);
		#1 chk(16'(irq_out), 16'h0000);
		// a pin claimed by the counter filters but raises nothing
		@(posedge ref_clk_in);
		high_speed_counter_input <= 8'h10;
		mv(4, 1'b1);
		#1 chk({ext_req_out, 7'h00, irq_out}, 16'h0000);
		chk(filtered_out, 16'h0070);
		rstn_in <= 1'b0;
		#1 chk(filtered_out, 16'h0000);
		repeat (3) @(posedge ref_clk_in);
		rstn_in <= 1'b1;
		rd(IFEI_REG_FILTER, 16'h0004);
		complete_run();
	end
endmodule
`default_nettype wire
